// ### inc/prt_pkg.sv
// Constants, register map and field layout of the prescaled reload timer.
// Assumes one 50 MHz clock domain and a 32-bit APB master at the registers.
package prt_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------
    localparam int          PRT_AW       = 8;
    localparam logic [7:0]  PRT_A_CTRL   = 8'h00;
    localparam logic [7:0]  PRT_A_MODE   = 8'h04;
    localparam logic [7:0]  PRT_A_PRE    = 8'h08;
    localparam logic [7:0]  PRT_A_SEC    = 8'h0c;
    localparam logic [7:0]  PRT_A_PRI    = 8'h10;
    localparam logic [7:0]  PRT_A_ONE    = 8'h14;
    localparam logic [7:0]  PRT_A_ISTAT  = 8'h18;
    localparam logic [7:0]  PRT_A_IMASK  = 8'h1c;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int          PRT_B_RUN    = 0;
    localparam int          PRT_B_STAT   = 1;
    localparam int          PRT_B_HALT   = 2;
    localparam int          PRT_B_UF     = 0;
    localparam logic [7:0]  PRT_ALL_ONES = 8'hff;
    localparam logic [7:0]  PRT_ZERO8    = 8'h00;
    localparam logic [2:0]  PRT_DIV8_END = 3'h7;

    // Count source encodings of the two-bit select field.
    typedef enum logic [1:0] {
        PRT_SRC_F1   = 2'b00,
        PRT_SRC_F8   = 2'b01,
        PRT_SRC_COMP = 2'b10,
        PRT_SRC_F2   = 2'b11
    } prt_src_t;

    // Mode configuration register, bits 7..0 of its word.
    typedef struct packed {
        logic       cutoff;       // Bit 7: count source cutoff.
        logic       rsvd6;        // Bit 6: reads zero.
        prt_src_t   src;          // Bits 5:4: count source select.
        logic       wr_target;    // Bit 3: write target select.
        logic       rsvd2;        // Bit 2: reads zero.
        logic [1:0] mode;         // Bits 1:0: mode, only basic mode acts.
    } prt_mode_t;

    localparam prt_mode_t   PRT_MODE_RST = '0;

endpackage : prt_pkg

// ### test/prt_timer_tb_top.sv
// Self-checking bench for the prescaled reload timer in basic interval mode.
// Assumes prt_pkg and prt_timer are compiled first; the bench acts as APB master.
`timescale 1ns/1ns
module prt_timer_tb_top
    import prt_pkg::*;
;
    // ----------------------------------------------------------------
    // Stimulus and observation signals
    // ----------------------------------------------------------------
    logic        clk;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic        comp_uflow  = 1'b0;
    logic [2:0]  comp_cnt    = 3'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        uflow;
    int          errors;
    int          checks_done;
    int          mult[4] = '{1, 8, 5, 2};    // Clock cycles per tick for codes 00, 01, 10, 11.

    prt_timer prt_timer_i (
        .clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .comp_uflow_i(comp_uflow), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq), .uflow_o(uflow)
    );

    // Clock generation.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Companion underflow every fifth cycle, so its tick rate differs from every divided clock.
    always @(posedge clk) begin
        comp_cnt   <= (comp_cnt == 3'h4) ? 3'h0 : comp_cnt + 3'h1;
        comp_uflow <= (comp_cnt == 3'h4);
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One APB transfer; request held until pready is sampled high, one idle edge after release.
    task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr_en;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            errors++;
            give_verdict();
        end
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, exp);
    endtask : rdc

    // Counts edges until the next underflow pulse is seen; a lost pulse ends the run.
    task automatic wait_uf(output int n);
        @(posedge clk);
        n = 1;
        while (uflow !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 2000) begin
            errors++;
            give_verdict();
        end
    endtask : wait_uf

    task automatic per(input int exp);
        int n;
        wait_uf(n);
        wait_uf(n);
        chk(32'(n), 32'(exp));
    endtask : per

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        logic [31:0] q;
        logic        e;
        rdc(PRT_A_PRE, 32'hff);
        rdc(PRT_A_PRI, 32'hff);
        rdc(PRT_A_CTRL, 32'h0);
        apb(1'b0, 8'h20, 32'h0, q, e);
        chk(32'(e), 32'h1);
    endtask : t_reset

    // Period per source with dead secondary and one-shot settings; config changes only when stopped.
    task automatic t_sources;
        wr(PRT_A_SEC, 32'h0);
        wr(PRT_A_ONE, 32'hff);
        wr(PRT_A_PRE, 32'h2);
        wr(PRT_A_PRI, 32'h3);
        rdc(PRT_A_PRE, 32'h2);
        rdc(PRT_A_PRI, 32'h3);
        for (int i = 0; i < 4; i++) begin
            wr(PRT_A_MODE, 32'(i) << 4);
            wr(PRT_A_CTRL, 32'h1);
            per(12 * mult[i]);
            wr(PRT_A_CTRL, 32'h0);
        end
    endtask : t_sources

    task automatic t_irq;
        chk(32'(irq), 32'h0);
        wr(PRT_A_IMASK, 32'h1);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h1);
        rdc(PRT_A_ISTAT, 32'h1);
        rdc(PRT_A_ISTAT, 32'h0);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
    endtask : t_irq

    task automatic t_stop_hold;
        logic [31:0] a;
        logic [31:0] b;
        logic        e;
        wr(PRT_A_CTRL, 32'h1);
        repeat (30) @(posedge clk);
        wr(PRT_A_CTRL, 32'h0);
        apb(1'b0, PRT_A_PRE, 32'h0, a, e);
        apb(1'b0, PRT_A_PRI, 32'h0, b, e);
        repeat (40) @(posedge clk);
        rdc(PRT_A_PRE, a);
        rdc(PRT_A_PRI, b);
        rdc(PRT_A_CTRL, 32'h0);
    endtask : t_stop_hold

    task automatic t_halt;
        wr(PRT_A_CTRL, 32'h1);
        repeat (20) @(posedge clk);
        rdc(PRT_A_CTRL, 32'h3);
        // The run bit stays set in the halt write, so only the halt bit can stop the count.
        wr(PRT_A_CTRL, 32'h5);
        rdc(PRT_A_PRE, 32'hff);
        rdc(PRT_A_PRI, 32'hff);
        repeat (40) @(posedge clk);
        rdc(PRT_A_CTRL, 32'h0);
        rdc(PRT_A_PRE, 32'hff);
    endtask : t_halt

    // Running writes: select clear loads the counter at the next prescaler underflow; select set waits for the next reload.
    task automatic t_run_write;
        int n;
        wr(PRT_A_MODE, 32'h0);
        wr(PRT_A_PRE, 32'h0);
        wr(PRT_A_PRI, 32'h7);
        wr(PRT_A_CTRL, 32'h1);
        per(8);
        wr(PRT_A_PRI, 32'h1);
        wait_uf(n);
        chk(32'(n), 32'h3);
        per(2);
        wr(PRT_A_CTRL, 32'h0);
        wr(PRT_A_MODE, 32'h8);
        wr(PRT_A_PRI, 32'h7);
        wr(PRT_A_CTRL, 32'h1);
        wait_uf(n);
        wr(PRT_A_PRI, 32'h1);
        wait_uf(n);
        chk(32'(n), 32'h5);
        per(2);
        wr(PRT_A_CTRL, 32'h0);
    endtask : t_run_write

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        errors = 0;
        checks_done = 0;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_sources();
        t_irq();
        t_stop_hold();
        t_halt();
        t_run_write();
        give_verdict();
    end
endmodule : prt_timer_tb_top

// ### verilog/prt_timer.sv
// Basic interval mode of an 8-bit prescaler cascaded with an 8-bit timer.
// Assumes an APB3 master on clk_i and a companion underflow pulse on clk_i.
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ns
module prt_timer
    import prt_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [PRT_AW-1:0] paddr_i,
    input  wire logic [31:0]       pwdata_i,
    input  wire logic              comp_uflow_i,
    output logic      [31:0]       prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    output logic                   irq_o,
    output logic                   uflow_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    prt_mode_t  mode_cfg;
    logic       run_req;
    logic       running;
    logic [7:0] pre_reload;
    logic [7:0] pri_reload;
    logic [7:0] sec_reload;
    logic [7:0] oneshot;
    logic [7:0] pre_cnt;
    logic [7:0] tmr_cnt;
    logic       pre_pend;
    logic       pri_pend;
    logic [2:0] div;
    logic       irq_stat;
    logic       irq_mask;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // The slave answers in the second cycle of every transfer.
    wire        setup   = psel_i & ~penable_i;
    wire        acc     = psel_i & penable_i & pready_o;
    wire        wr      = acc & pwrite_i;
    wire        hit_ctl = paddr_i == PRT_A_CTRL;
    wire        hit_mod = paddr_i == PRT_A_MODE;
    wire        hit_pre = paddr_i == PRT_A_PRE;
    wire        hit_sec = paddr_i == PRT_A_SEC;
    wire        hit_pri = paddr_i == PRT_A_PRI;
    wire        hit_one = paddr_i == PRT_A_ONE;
    wire        hit_ist = paddr_i == PRT_A_ISTAT;
    wire        hit_imk = paddr_i == PRT_A_IMASK;
    wire        mapped  = hit_ctl | hit_mod | hit_pre | hit_sec | hit_pri | hit_one | hit_ist | hit_imk;
    wire        wr_ctl  = wr & hit_ctl;
    wire        halt    = wr_ctl & pwdata_i[PRT_B_HALT];
    wire        wr_pre  = wr & hit_pre;
    wire        wr_pri  = wr & hit_pri;
    wire [7:0]  wbyte   = pwdata_i[7:0];
    wire        rd_ist  = acc & ~pwrite_i & hit_ist;

    // Live counts are returned, not reload values.
    wire [7:0]  rbyte   = hit_ctl ? {5'h00, 1'b0, running, run_req}                             :
                          hit_mod ? {mode_cfg.cutoff, 1'b0, mode_cfg.src, mode_cfg.wr_target,
                                     1'b0, mode_cfg.mode}                                    :
                          hit_pre ? pre_cnt                                                   :
                          hit_pri ? tmr_cnt                                                   :
                          hit_ist ? {7'h00, irq_stat}                                         :
                          hit_imk ? {7'h00, irq_mask}                                         :
                                    PRT_ZERO8;

    // ------------------------------------------------------------
    // Count source
    // ------------------------------------------------------------
    // Divided clocks are strobes from one free running divider.
    wire        tick_f2  = div[0];
    wire        tick_f8  = div == PRT_DIV8_END;
    wire        src_sel  = (mode_cfg.src == PRT_SRC_F1)   ? 1'b1         :
                           (mode_cfg.src == PRT_SRC_F8)   ? tick_f8      :
                           (mode_cfg.src == PRT_SRC_COMP) ? comp_uflow_i :
                                                            tick_f2;
    // Stop takes effect on the edge of the write; the running flag clears on that same edge.
    wire        cnt_en   = run_req & ~halt & ~(wr_ctl & ~pwdata_i[PRT_B_RUN]);
    wire        src_tick = cnt_en & src_sel & ~mode_cfg.cutoff;
    wire        pre_uf   = src_tick & ~pre_pend & (pre_cnt == PRT_ZERO8);
    wire        tmr_uf   = pre_uf & ~pri_pend & (tmr_cnt == PRT_ZERO8);
    // A direct write goes to the counter only when stopped; a running write with the select bit clear is queued.
    wire        direct   = ~running;
    wire        both     = running & ~mode_cfg.wr_target;

    // ------------------------------------------------------------
    // Free running divider for f2 and f8
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            div <= 3'h0;
        end else begin
            div <= div + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Control and configuration registers
    // ------------------------------------------------------------
    // The secondary and one-shot words are stored only; nothing reads them here.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            run_req  <= 1'b0;
            running  <= 1'b0;
            mode_cfg <= PRT_MODE_RST;
            oneshot  <= PRT_ZERO8;
            irq_mask <= 1'b0;
        end else begin
            if (halt) begin
                run_req <= 1'b0;
            end else if (wr_ctl) begin
                run_req <= pwdata_i[PRT_B_RUN];
            end
            running <= cnt_en;
            if (wr & hit_mod) begin
                mode_cfg <= prt_mode_t'({wbyte[7], 1'b0, wbyte[5:3], 1'b0, wbyte[1:0]});
            end
            if (wr & hit_one) begin
                oneshot <= wbyte;
            end
            if (wr & hit_imk) begin
                irq_mask <= pwdata_i[PRT_B_UF];
            end
        end
    end

    // ------------------------------------------------------------
    // Reload registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pre_reload <= PRT_ALL_ONES;
            pri_reload <= PRT_ALL_ONES;
            sec_reload <= PRT_ALL_ONES;
        end else if (halt) begin
            pre_reload <= PRT_ALL_ONES;
            pri_reload <= PRT_ALL_ONES;
            sec_reload <= PRT_ALL_ONES;
        end else begin
            if (wr_pre) begin
                pre_reload <= wbyte;
            end
            if (wr_pri) begin
                pri_reload <= wbyte;
            end
            if (wr & hit_sec) begin
                sec_reload <= wbyte;
            end
        end
    end

    // ------------------------------------------------------------
    // Prescaler counter
    // ------------------------------------------------------------
    // A write while running with the select bit clear is held pending until the next source tick,
    // so between ticks the counter changes only on a forced halt, which presets it to all ones.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pre_cnt  <= PRT_ALL_ONES;
            pre_pend <= 1'b0;
        end else if (halt) begin
            pre_cnt  <= PRT_ALL_ONES;
            pre_pend <= 1'b0;
        end else if (wr_pre & direct) begin
            pre_cnt  <= wbyte;
            pre_pend <= 1'b0;
        end else if (src_tick) begin
            pre_cnt  <= (pre_pend | pre_uf) ? pre_reload : pre_cnt - 8'h01;
            pre_pend <= wr_pre & both;
        end else if (wr_pre & both) begin
            pre_pend <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Timer counter
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tmr_cnt  <= PRT_ALL_ONES;
            pri_pend <= 1'b0;
        end else if (halt) begin
            tmr_cnt  <= PRT_ALL_ONES;
            pri_pend <= 1'b0;
        end else if (wr_pri & direct) begin
            tmr_cnt  <= wbyte;
            pri_pend <= 1'b0;
        end else if (pre_uf) begin
            tmr_cnt  <= (pri_pend | tmr_uf) ? pri_reload : tmr_cnt - 8'h01;
            pri_pend <= wr_pri & both;
        end else if (wr_pri & both) begin
            pri_pend <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, mask and outputs
    // ------------------------------------------------------------
    // A read clears only the bit that it returned, and a new underflow wins.
    wire next_stat = (irq_stat & ~(rd_ist & prdata_o[PRT_B_UF])) | tmr_uf;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_stat <= 1'b0;
            irq_o    <= 1'b0;
            uflow_o  <= 1'b0;
        end else begin
            irq_stat <= next_stat;
            irq_o    <= next_stat & irq_mask;
            uflow_o  <= tmr_uf;
        end
    end

    // ------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else begin
            pready_o  <= setup;
            pslverr_o <= setup & ~mapped;
            if (setup) begin
                prdata_o <= {24'h00_0000, rbyte};
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Software the checks below assume no source change while counting.
    AST_UF_RELOAD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (tmr_uf && !wr_pri && !halt) |=> tmr_cnt == $past(pri_reload))
        else $error("Timer did not reload from primary on underflow.");
    AST_IRQ_SET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        tmr_uf |=> irq_stat && uflow_o)
        else $error("Underflow did not raise interrupt status.");
    AST_HALT_PRESET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        halt |=> !run_req && pre_cnt == PRT_ALL_ONES && tmr_cnt == PRT_ALL_ONES
                 && pri_reload == PRT_ALL_ONES && sec_reload == PRT_ALL_ONES)
        else $error("Forced halt did not stop and preset.");
    AST_HALT_NOW: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        halt |-> !src_tick ##1 (!running) [*2])
        else $error("Counting continued on the forced halt edge.");
    AST_STOP_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!run_req && !wr_pre && !wr_pri && !halt) |=> $stable(pre_cnt) && $stable(tmr_cnt))
        else $error("Counters moved while stopped.");
    AST_START: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_ctl && pwdata_i[PRT_B_RUN] && !halt) |=> run_req ##1 running)
        else $error("Run request did not start counting.");
    AST_F8: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (src_tick && mode_cfg.src == PRT_SRC_F8) |-> div == PRT_DIV8_END)
        else $error("Divide by eight ticked off its strobe.");
    AST_RELOAD_ONLY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_pre && running && mode_cfg.wr_target && !halt) |=> !pre_pend && pre_reload == $past(wbyte))
        else $error("Reload-only write touched the prescaler counter.");
    AST_BOTH_PEND: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_pri && running && !mode_cfg.wr_target && !halt && !pre_uf) |=> pri_pend)
        else $error("Running write did not queue the timer load.");
    AST_READ_LIVE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (setup && hit_pre) |=> prdata_o[7:0] == $past(pre_cnt))
        else $error("Prescaler read did not return the live count.");
    AST_STOP_WRITE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_pri && !running && !halt) |=> tmr_cnt == $past(wbyte))
        else $error("Stopped write did not reach the timer counter.");

    COV_UFLOW:  cover property (@(posedge clk_i) disable iff (!rst_n_i) tmr_uf);
    COV_HALT:   cover property (@(posedge clk_i) disable iff (!rst_n_i) running && halt);
    COV_RELOAD: cover property (@(posedge clk_i) disable iff (!rst_n_i) wr_pre && running && mode_cfg.wr_target);
    COV_IRQ:    cover property (@(posedge clk_i) disable iff (!rst_n_i) irq_o);

endmodule : prt_timer
